// ### verilog/mip_top.sv
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
//Functional notes
// - On acknowledge, save return PC and status word into the save registers.
// - On acknowledge, write source code to cause low half, upper half kept.
// - On acknowledge, set interrupt-disable and clear trap-active in status word.
// - Finally load the PC with the acknowledged source's handler address.
// - Hold requests pending while masked, nmi-active set or interrupt-disable set.
// - Pending request is serviced once unmasked or both flags return to zero.
// - Return with trap and nmi flags clear restores PC and status from saves.
// - Each source has a three-bit level field used in arbitration.
// - Same-level coincident requests go in fixed default order.
// - Any acknowledge sets the interrupt-disable flag to one.
// - With interrupts enabled, a strictly higher level than in service is taken.
// - A request at the in-service level waits until that servicing ends.
// - A request at a lower level than in service stays pending.
// - Highest programmed priority wins among eligible requests regardless of arrival.
// - Among equal levels the higher default priority wins regardless of arrival.
// - Level 0 is highest and level 7 lowest, binary three-bit coding.
// - Default order treats source index 0 as the highest.
// - Hardware clears a source's request flag when it is acknowledged.
// - Mask flag one holds the request pending; zero allows servicing.
module mip_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [mip_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [mip_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral requests, one-cycle pulses
	input wire logic [mip_pkg::NSRC-1:0] irq_req,
	// Core side
	input wire logic [31:0] restore_pc,
	output logic [31:0] pc_out,
	output logic ack_pulse,
	output logic [mip_pkg::SRC_W-1:0] ack_source,
	output logic return_pulse,
	output logic interrupt_disable_flag
);
	import mip_pkg::*;

	mip_regbus_if rb ();
	mip_arb_if arb ();

	// Bus front end; decoding stays here
	mip_axil_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rb(rb.slave)
	);

	// Winner search only; acceptance is gated here
	mip_arbiter u_arb (
		.arb(arb.arb)
	);

	// One aligned control word per source
	function automatic logic is_src(input logic [ADDR_W-1:0] a);
		return (a >= OFF_SRC_BASE) && (a < OFF_SRC_END) && (a[1:0] == 2'h0);
	endfunction : is_src

	// Only valid after is_src has passed
	function automatic logic [SRC_W-1:0] src_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - OFF_SRC_BASE;
		return d[SRC_W+1:2];
	endfunction : src_idx

	// Byte lanes of a full-word register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nv[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Anything else answers with an error
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return is_src(a)
			|| a == OFF_STATUS
			|| a == OFF_SAVED_PC
			|| a == OFF_SAVED_SW
			|| a == OFF_CAUSE
			|| a == OFF_COMMAND
			|| a == OFF_IN_SERVICE
			|| a == OFF_PC
			|| a == OFF_LAST_ACK;
	endfunction : is_mapped

	// Architectural state
	mip_state_t state, next_state;
	logic [31:0] status_word, next_status_word;
	logic [31:0] saved_return_pc, next_saved_return_pc;
	logic [31:0] saved_status_word, next_saved_status_word;
	logic [31:0] cause_code_reg, next_cause_code_reg;
	logic [31:0] pc, next_pc;
	logic [NLVL-1:0] in_service_level_reg, next_in_service_level_reg;
	logic [NSRC-1:0] request_flag, next_request_flag;
	logic [NSRC-1:0] source_mask_flag, next_source_mask_flag;
	logic [LVL_W-1:0] priority_level_field [NSRC];
	logic [LVL_W-1:0] next_priority_level_field [NSRC];
	logic [SRC_W-1:0] win_src, next_win_src;
	logic [LVL_W-1:0] win_lvl, next_win_lvl;
	logic ret_done, next_ret_done;
	// Decoded helpers
	logic svc_found;
	logic [LVL_W-1:0] svc_lvl;
	logic accept;
	logic cmd_wr;
	logic [31:0] sw_data;
	logic [15:0] maskable_cause_code;

	// Level currently in service: lowest set bit is the most urgent
	always_comb begin
		svc_found = 1'b0;
		svc_lvl = '0;
		for (int l = NLVL - 1; l >= 0; l--) begin
			if (in_service_level_reg[l]) begin
				svc_found = 1'b1;
				svc_lvl = LVL_W'(l);
			end
		end
	end

	// Masked sources never reach the arbiter
	assign arb.cand = request_flag & ~source_mask_flag;
	assign arb.prio = priority_level_field;

	// Only the single best candidate is tested; anything that loses to it is blocked too
	// A bit cleared by a return counts from the next cycle
	assign accept = (state == MIP_RUN)
		&& arb.win_valid
		&& !status_word[SW_ID_BIT] && !status_word[SW_NP_BIT]
		&& (!svc_found || arb.win_lvl < svc_lvl);

	// Strobes and cause of the held winner
	assign cmd_wr = rb.wr_en && rb.wr_addr == OFF_COMMAND;
	assign sw_data = rb.wr_data;
	assign maskable_cause_code = CODE_BASE + (16'(win_src) << VEC_SHIFT);

	// Register reads
	// No side effects; command reads as zero
	always_comb begin
		rb.rd_data = '0;
		rb.rd_err = !is_mapped(rb.rd_addr);
		rb.wr_err = !is_mapped(rb.wr_addr);
		if (is_src(rb.rd_addr)) begin
			rb.rd_data[CTL_FLAG_BIT] = request_flag[src_idx(rb.rd_addr)];
			rb.rd_data[CTL_MASK_BIT] = source_mask_flag[src_idx(rb.rd_addr)];
			rb.rd_data[LVL_W-1:0] = priority_level_field[src_idx(rb.rd_addr)];
		end else begin
			unique case (rb.rd_addr)
				OFF_STATUS: rb.rd_data = status_word;
				OFF_SAVED_PC: rb.rd_data = saved_return_pc;
				OFF_SAVED_SW: rb.rd_data = saved_status_word;
				OFF_CAUSE: rb.rd_data = cause_code_reg;
				OFF_IN_SERVICE: rb.rd_data[NLVL-1:0] = in_service_level_reg;
				OFF_PC: rb.rd_data = pc;
				OFF_LAST_ACK: rb.rd_data[SRC_W-1:0] = win_src;
				default: rb.rd_data = '0;
			endcase
		end
	end

	// Next state: software writes first, hardware updates override them
	always_comb begin
		// Hold unless changed below
		next_state = state;
		next_status_word = status_word;
		next_saved_return_pc = saved_return_pc;
		next_saved_status_word = saved_status_word;
		next_cause_code_reg = cause_code_reg;
		next_pc = pc;
		next_in_service_level_reg = in_service_level_reg;
		next_request_flag = request_flag;
		next_source_mask_flag = source_mask_flag;
		next_priority_level_field = priority_level_field;
		next_win_src = win_src;
		next_win_lvl = win_lvl;
		next_ret_done = 1'b0;

		// Software side of the register file
		if (rb.wr_en) begin
			if (is_src(rb.wr_addr)) begin
				if (rb.wr_strb[0]) begin
					next_request_flag[src_idx(rb.wr_addr)] = sw_data[CTL_FLAG_BIT];
					next_source_mask_flag[src_idx(rb.wr_addr)] = sw_data[CTL_MASK_BIT];
					next_priority_level_field[src_idx(rb.wr_addr)] = sw_data[LVL_W-1:0];
				end
			end else begin
				unique case (rb.wr_addr)
					// A load that clears both flags reopens arbitration
					OFF_STATUS: next_status_word = merge(status_word, sw_data, rb.wr_strb);
					OFF_SAVED_PC: next_saved_return_pc = merge(saved_return_pc, sw_data,
						rb.wr_strb);
					OFF_SAVED_SW: next_saved_status_word = merge(saved_status_word, sw_data,
						rb.wr_strb);
					OFF_CAUSE: next_cause_code_reg = merge(cause_code_reg, sw_data,
						rb.wr_strb);
					OFF_PC: next_pc = merge(pc, sw_data, rb.wr_strb);
					default: next_pc = next_pc;
				endcase
			end
		end

		// Commands act only between entry sequences
		if (cmd_wr && rb.wr_strb[0] && state == MIP_RUN) begin
			if (sw_data[CMD_MASK_BIT]) begin
				next_status_word[SW_ID_BIT] = 1'b1;
			end else if (sw_data[CMD_UNMASK_BIT]) begin
				next_status_word[SW_ID_BIT] = 1'b0;
			end
			// Nmi and trap returns belong to other logic; they are ignored here
			if (sw_data[CMD_RETURN_BIT] && !status_word[SW_EP_BIT]
				&& !status_word[SW_NP_BIT]) begin
				next_pc = saved_return_pc;
				next_status_word = saved_status_word;
				if (svc_found) begin
					next_in_service_level_reg[svc_lvl] = 1'b0;
				end
				// Tells the core the restore happened
				next_ret_done = 1'b1;
			end
		end

		// Entry: pick, then save, then jump
		unique case (state)
			MIP_RUN: begin
				if (accept) begin
					next_state = MIP_SAVE;
					next_win_src = arb.win_src;
					next_win_lvl = arb.win_lvl;
					next_request_flag[arb.win_src] = 1'b0;
				end
			end
			MIP_SAVE: begin
				// Wins over a software write this cycle
				next_saved_return_pc = restore_pc;
				next_saved_status_word = status_word;
				next_cause_code_reg[15:0] = maskable_cause_code;
				next_status_word[SW_ID_BIT] = 1'b1;
				next_status_word[SW_EP_BIT] = 1'b0;
				next_in_service_level_reg[win_lvl] = 1'b1;
				next_state = MIP_ENTER;
			end
			MIP_ENTER: begin
				// Last, so no half-built entry is seen
				next_pc = HANDLER_BASE + (32'(win_src) << VEC_SHIFT);
				next_state = MIP_RUN;
			end
		endcase

		// New requests set last so they survive a clear in the same cycle
		next_request_flag = next_request_flag | irq_req;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Status reset leaves interrupts disabled
			state <= MIP_RUN;
			status_word <= STATUS_RST;
			saved_return_pc <= '0;
			saved_status_word <= '0;
			cause_code_reg <= '0;
			pc <= PC_RST;
			in_service_level_reg <= '0;
			request_flag <= '0;
			// Sources start masked at the lowest level
			source_mask_flag <= {NSRC{CTL_MASK_RST}};
			for (int i = 0; i < NSRC; i++) begin
				priority_level_field[i] <= CTL_PRIO_RST;
			end
			win_src <= '0;
			win_lvl <= '0;
			ret_done <= 1'b0;
		end else begin
			state <= next_state;
			status_word <= next_status_word;
			saved_return_pc <= next_saved_return_pc;
			saved_status_word <= next_saved_status_word;
			cause_code_reg <= next_cause_code_reg;
			pc <= next_pc;
			in_service_level_reg <= next_in_service_level_reg;
			request_flag <= next_request_flag;
			source_mask_flag <= next_source_mask_flag;
			priority_level_field <= next_priority_level_field;
			win_src <= next_win_src;
			win_lvl <= next_win_lvl;
			ret_done <= next_ret_done;
		end
	end

	// Core side comes from flip-flops
	assign pc_out = pc;
	assign ack_pulse = (state == MIP_ENTER);
	assign ack_source = win_src;
	assign return_pulse = ret_done;
	assign interrupt_disable_flag = status_word[SW_ID_BIT];
endmodule : mip_top

// ### common/mip_pkg.sv
package mip_pkg;
	// Sources and levels
	localparam int NSRC = 26;
	localparam int SRC_W = 5;
	localparam int LVL_W = 3;
	localparam int NLVL = 8;
	localparam int ADDR_W = 12;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_SAVED_PC = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_SAVED_SW = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_CAUSE = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_COMMAND = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_IN_SERVICE = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_PC = 12'h018;
	localparam logic [ADDR_W-1:0] OFF_LAST_ACK = 12'h01c;
	localparam logic [ADDR_W-1:0] OFF_SRC_BASE = 12'h100;
	localparam logic [ADDR_W-1:0] OFF_SRC_END = 12'h168;
	// Status word bits
	localparam int SW_ID_BIT = 5;
	localparam int SW_EP_BIT = 6;
	localparam int SW_NP_BIT = 7;
	localparam logic [31:0] STATUS_RST = 32'h0000_0020;
	// Per-source control register fields
	localparam int CTL_FLAG_BIT = 7;
	localparam int CTL_MASK_BIT = 6;
	localparam logic CTL_MASK_RST = 1'h1;
	localparam logic [LVL_W-1:0] CTL_PRIO_RST = 3'h7;
	// Command register bits
	localparam int CMD_RETURN_BIT = 0;
	localparam int CMD_UNMASK_BIT = 1;
	localparam int CMD_MASK_BIT = 2;
	// Vectors and cause codes
	localparam logic [31:0] HANDLER_BASE = 32'h0000_0080;
	localparam logic [15:0] CODE_BASE = 16'h0080;
	localparam int VEC_SHIFT = 4;
	localparam logic [31:0] PC_RST = 32'h0000_0000;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Entry sequence
	typedef enum logic [2:0] {
		MIP_RUN = 3'h1,
		MIP_SAVE = 3'h2,
		MIP_ENTER = 3'h4
	} mip_state_t;
endpackage : mip_pkg

// ### common/mip_ifs.sv
`timescale 1ns/1ps
interface mip_regbus_if;
	import mip_pkg::*;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_err, rd_data, rd_err);
	modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface : mip_regbus_if

interface mip_arb_if;
	import mip_pkg::*;
	logic [NSRC-1:0] cand;
	logic [LVL_W-1:0] prio [NSRC];
	logic win_valid;
	logic [SRC_W-1:0] win_src;
	logic [LVL_W-1:0] win_lvl;
	modport arb (input cand, prio, output win_valid, win_src, win_lvl);
	modport core (output cand, prio, input win_valid, win_src, win_lvl);
endinterface : mip_arb_if

// ### verilog/mip_arbiter.sv
`timescale 1ns/1ps
module mip_arbiter (
	// Candidates and winner
	mip_arb_if.arb arb
);
	import mip_pkg::*;

	// Ascending scan with strict compare keeps the lowest index on a tie
	always_comb begin
		arb.win_valid = 1'b0;
		arb.win_src = '0;
		arb.win_lvl = '1;
		for (int i = 0; i < NSRC; i++) begin
			if (arb.cand[i] && (!arb.win_valid || arb.prio[i] < arb.win_lvl)) begin
				arb.win_valid = 1'b1;
				arb.win_src = SRC_W'(i);
				arb.win_lvl = arb.prio[i];
			end
		end
	end
endmodule : mip_arbiter

// ### verilog/mip_axil_slave.sv
`timescale 1ns/1ps
module mip_axil_slave (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address and data
	input wire logic [mip_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read
	input wire logic [mip_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register side
	mip_regbus_if.slave rb
);
	import mip_pkg::*;

	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic aw_hs, w_hs, have_aw, have_w;

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;

	always_comb begin
		aw_hs = s_axi_awvalid && s_axi_awready;
		w_hs = s_axi_wvalid && s_axi_wready;
		have_aw = aw_held || aw_hs;
		have_w = w_held || w_hs;
		next_aw_held = aw_held;
		next_aw_addr = aw_hs ? s_axi_awaddr : aw_addr;
		next_w_held = w_held;
		next_w_data = w_hs ? s_axi_wdata : w_data;
		next_w_strb = w_hs ? s_axi_wstrb : w_strb;
		next_bvalid = bvalid && !s_axi_bready;
		next_bresp = bresp;
		rb.wr_en = have_aw && have_w;
		rb.wr_addr = aw_held ? aw_addr : s_axi_awaddr;
		rb.wr_data = w_held ? w_data : s_axi_wdata;
		rb.wr_strb = w_held ? w_strb : s_axi_wstrb;
		if (rb.wr_en) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = rb.wr_err ? RESP_SLVERR : RESP_OKAY;
		end else begin
			next_aw_held = have_aw;
			next_w_held = have_w;
		end
		rb.rd_en = s_axi_arvalid && s_axi_arready;
		rb.rd_addr = s_axi_araddr;
		next_rvalid = rvalid && !s_axi_rready;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rb.rd_en) begin
			next_rvalid = 1'b1;
			next_rdata = rb.rd_data;
			next_rresp = rb.rd_err ? RESP_SLVERR : RESP_OKAY;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end
endmodule : mip_axil_slave

// ### tb/mip_src_model.sv
`timescale 1ns/1ps
module mip_src_model (
	// Clock
	input wire logic aclk,
	// Requests and resume point
	output logic [mip_pkg::NSRC-1:0] irq_req,
	output logic [31:0] restore_pc
);
	import mip_pkg::*;
	initial begin
		irq_req = '0;
		restore_pc = 32'h0000_1000;
	end
	// One-cycle pulses; several sources may fire in the same cycle
	task automatic fire(input logic [NSRC-1:0] v);
		@(posedge aclk);
		irq_req <= v;
		@(posedge aclk);
		irq_req <= '0;
	endtask : fire
	// Core resume point moves only between requests
	task automatic jump(input logic [31:0] a);
		restore_pc <= a;
	endtask : jump
endmodule : mip_src_model

// ### tb/mip_top_assertions.sv
`timescale 1ns/1ps
module mip_top_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core side
	input wire logic [31:0] pc_out,
	input wire logic ack_pulse,
	input wire logic [mip_pkg::SRC_W-1:0] ack_source,
	input wire logic return_pulse,
	input wire logic interrupt_disable_flag
);
	import mip_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_ack_single: assert property (ack_pulse |=> !ack_pulse [*2])
		else $error("ack pulse too long");
	a_ack_sets_id: assert property (ack_pulse |-> interrupt_disable_flag)
		else $error("disable flag low on ack");
	a_ack_vector: assert property (ack_pulse |=>
		pc_out == HANDLER_BASE + (32'(ack_source) << VEC_SHIFT))
		else $error("pc not at handler");
	// Acceptance needs the disable flag low at the accepting edge
	a_ack_gate: assert property (ack_pulse |-> $past(!interrupt_disable_flag, 2))
		else $error("ack while disabled");
	a_ret_single: assert property (return_pulse |=> !return_pulse)
		else $error("return pulse too long");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	c_entry: cover property (ack_pulse);
	c_return: cover property (return_pulse);
	c_nested: cover property (ack_pulse ##[4:200] ack_pulse);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : mip_top_chk

bind mip_top mip_top_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pc_out, .ack_pulse,
	.ack_source, .return_pulse, .interrupt_disable_flag);

// ### tb/test_maskable_irq_priority_entry.sv
`timescale 1ns/1ps
module test_maskable_irq_priority_entry;
	import mip_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, ack_pulse, return_pulse, id_flag;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, pc_out, restore_pc;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [NSRC-1:0] irq_req;
	logic [SRC_W-1:0] ack_source;
	logic [SRC_W-1:0] acks[$];
	int bad_count, total_checks, cyc, rets, n_ret, lvl[NSRC], svc[$];
	bit mid, nmi, msk[NSRC], pend[NSRC];

	mip_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq_req(irq_req), .restore_pc(restore_pc),
		.pc_out(pc_out), .ack_pulse(ack_pulse), .ack_source(ack_source),
		.return_pulse(return_pulse), .interrupt_disable_flag(id_flag));
	mip_src_model u_src (.aclk(aclk), .irq_req(irq_req), .restore_pc(restore_pc));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc++;
		if (aresetn && ack_pulse === 1'b1) acks.push_back(ack_source);
		if (aresetn && return_pulse === 1'b1) rets++;
		if (cyc > 30000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic stop_test;
		if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t reg %h exp %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_ack(input logic [SRC_W-1:0] got, input logic [SRC_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t ack %h exp %h", $time, got, exp);
		end
	endtask : chk_ack

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk_reg({30'h0, r}, {30'h0, RESP_OKAY});
		chk_reg(d, e);
	endtask : rchk

	// Expected winner, or -1 while everything must stay pending
	function automatic int pick;
		int b, s;
		b = -1;
		s = NLVL;
		foreach (svc[k]) if (svc[k] < s) s = svc[k];
		for (int i = 0; i < NSRC; i++)
			if (pend[i] && !msk[i] && (b < 0 || lvl[i] < lvl[b])) b = i;
		if (mid || nmi || (b >= 0 && lvl[b] >= s)) b = -1;
		return b;
	endfunction : pick

	task automatic settle;
		int e, n;
		logic [SRC_W-1:0] g;
		e = pick();
		n = 0;
		while (acks.size() == 0 && n < 30) begin
			@(posedge aclk);
			n++;
		end
		g = acks.size() ? acks.pop_front() : 5'h1f;
		chk_ack(g, e < 0 ? 5'h1f : SRC_W'(e));
		if (e >= 0) begin
			pend[e] = 1'b0;
			svc.push_back(lvl[e]);
			mid = 1'b1;
		end
		chk_reg({31'h0, id_flag}, {31'h0, mid});
	endtask : settle

	task automatic cfg(input int i, input bit m, input int l);
		msk[i] = m;
		lvl[i] = l;
		// Flag written back as held so a pending request survives
		wr(OFF_SRC_BASE + ADDR_W'(4 * i), 32'({pend[i], m, 3'h0, 3'(l)}));
		settle();
	endtask : cfg

	task automatic cmd(input int v);
		int k;
		wr(OFF_COMMAND, 32'(v));
		if (v[CMD_MASK_BIT]) mid = 1'b1;
		else if (v[CMD_UNMASK_BIT]) mid = 1'b0;
		if (v[CMD_RETURN_BIT]) begin
			n_ret++;
			mid = 1'b0;
			k = -1;
			foreach (svc[j]) if (k < 0 || svc[j] < svc[k]) k = j;
			if (k >= 0) svc.delete(k);
		end
		settle();
	endtask : cmd

	task automatic wst(input logic [31:0] v);
		wr(OFF_STATUS, v);
		mid = v[SW_ID_BIT];
		nmi = v[SW_NP_BIT];
		settle();
	endtask : wst

	task automatic req(input logic [NSRC-1:0] v);
		u_src.fire(v);
		for (int i = 0; i < NSRC; i++) if (v[i]) pend[i] = 1'b1;
		settle();
	endtask : req

	initial begin
		logic [31:0] d, pcv, sp;
		logic [1:0] r;
		logic [NSRC-1:0] v;
		int m, s;
		void'($urandom(32'h4b89b660));
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		mid = 1'b1;
		for (int i = 0; i < NSRC; i++) begin
			lvl[i] = 7;
			msk[i] = 1'b1;
		end
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(OFF_STATUS, STATUS_RST);
		for (int i = 0; i < NSRC; i++)
			rchk(OFF_SRC_BASE + ADDR_W'(4 * i), {25'h0, CTL_MASK_RST, 3'h0, CTL_PRIO_RST});
		rd(12'h020, d, r);
		chk_reg({30'h0, r}, {30'h0, RESP_SLVERR});
		chk_reg(d, 32'h0);
		// Single entry and return, trap flag set beforehand
		pcv = $urandom & 32'hffff_fffc;
		u_src.jump(pcv);
		wr(OFF_CAUSE, 32'habcd_0000);
		wst(32'h0000_0040);
		cfg(3, 0, 5);
		req(NSRC'(1) << 3);
		rchk(OFF_SAVED_PC, pcv);
		rchk(OFF_SAVED_SW, 32'h0000_0040);
		rchk(OFF_CAUSE, {16'habcd, CODE_BASE + 16'(3 << VEC_SHIFT)});
		rchk(OFF_STATUS, STATUS_RST);
		rchk(OFF_PC, HANDLER_BASE + (32'(3) << VEC_SHIFT));
		chk_reg(pc_out, HANDLER_BASE + (32'(3) << VEC_SHIFT));
		rchk(OFF_SRC_BASE + 12'h00c, 32'h0000_0005);
		rchk(OFF_IN_SERVICE, 32'h0000_0020);
		cmd(1 << CMD_RETURN_BIT);
		rchk(OFF_PC, pcv);
		chk_reg(pc_out, pcv);
		rchk(OFF_STATUS, 32'h0000_0040);
		rchk(OFF_IN_SERVICE, 32'h0);
		wst(32'h0);
		// Nmi-active flag alone holds an unmasked request
		wst(32'h0000_0080);
		req(NSRC'(1) << 3);
		wst(32'h0);
		cmd(1 << CMD_RETURN_BIT);
		// Random levels, coincident and staggered arrival, one masked source
		for (int k = 0; k < 8; k++) begin
			cmd(1 << CMD_MASK_BIT);
			v = '0;
			repeat (4) begin
				s = $urandom % NSRC;
				cfg(s, 0, $urandom % (4 << (k % 2)));
				v[s] = 1'b1;
			end
			do m = $urandom % NSRC; while (v[m]);
			cfg(m, 1, 0);
			if (k % 2) begin
				for (int i = NSRC - 1; i >= 0; i--) if (v[i]) req(NSRC'(1) << i);
			end else req(v);
			req(NSRC'(1) << m);
			cmd(1 << CMD_UNMASK_BIT);
			repeat (4) cmd(1 << CMD_RETURN_BIT);
			cfg(m, 0, 7);
			cmd(1 << CMD_RETURN_BIT);
		end
		// Nesting by level
		cfg(7, 0, 3);
		cfg(8, 0, 3);
		cfg(9, 0, 4);
		cfg(10, 0, 1);
		req(NSRC'(1) << 7);
		rd(OFF_SAVED_PC, sp, r);
		cmd(1 << CMD_UNMASK_BIT);
		req(NSRC'(1) << 8);
		req(NSRC'(1) << 9);
		req(NSRC'(1) << 10);
		cmd(1 << CMD_RETURN_BIT);
		cmd(1 << CMD_MASK_BIT);
		wr(OFF_SAVED_PC, sp);
		cmd(1 << CMD_RETURN_BIT);
		cmd(1 << CMD_RETURN_BIT);
		cmd(1 << CMD_RETURN_BIT);
		chk_reg(rets, n_ret);
		stop_test();
	end
endmodule : test_maskable_irq_priority_entry
